// File: design/rxm_monitor.sv
`timescale 1ns/1ps
// Operation
// - alarm detection only under host register control with clock recovery active
// - e1, criterion 0: alarm after two consecutive 512-bit blocks under 3 zeros
// - e1, criterion 1: alarm after one 512-bit block under 3 zeros
// - e1 criterion 1: alarm clears after a 512-bit block with 3+ zeros
// - t1: alarm when an 8192-bit block holds fewer than 9 zeros
// - t1: alarm clears after an 8192-bit block with 9+ zeros
// - coded lines detect bpv and excess zeros, hdb3 also cv; strap mode reports all
// - ami: only bipolar violations reach the error pin
// - errors reported only in single rail, on the negative rail pin
// - host coded: code violations reported when mask bit 0, hidden when 1
// - host coded: excess zeros reported when bit 1; bpv always reported
// - line code select 1 means ami, 0 means b8zs or hdb3
// - recovery bypass bit 0 recovers clock, 1 bypasses and outputs raw rails
`include "rxm_map.svh"

module rxm_monitor #(
   parameter int T1_BLOCK = `RXM_T1_BLOCK,
   parameter int E1_BLOCK = `RXM_E1_BLOCK
) (
   // apb
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // recovered line
   input  wire logic        rx_clk,
   input  wire logic        rx_pos,
   input  wire logic        rx_neg,
   // straps
   input  wire logic        host_mode,
   input  wire logic        line_code_pin,
   input  wire logic        single_rail_pin,
   input  wire logic        e1_pin,
   // outputs
   output logic             rx_data_out,
   output logic             receive_negative_rail,
   output logic             ais_out
);
   import rxm_pkg::*;

   localparam int BW = $clog2(T1_BLOCK);
   localparam int ZW = 4;

   initial begin
      if (T1_BLOCK < E1_BLOCK || E1_BLOCK < 16 || T1_BLOCK > 65536)
         $error("rxm_monitor: unusable block lengths");
   end

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [6:0] s1_reg;
   logic [6:0] s2_reg;
   logic       clk_d_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg    <= 7'h00;
         s2_reg    <= 7'h00;
         clk_d_reg <= 1'b0;
      end else begin
         s1_reg    <= {e1_pin, single_rail_pin, line_code_pin, host_mode,
                       rx_neg, rx_pos, rx_clk};
         s2_reg    <= s1_reg;
         clk_d_reg <= s2_reg[0];
      end
   end

   logic bit_stb;
   logic pos_s;
   logic neg_s;
   assign bit_stb = s2_reg[0] & ~clk_d_reg;
   assign pos_s   = s2_reg[1];
   assign neg_s   = s2_reg[2];

   ////////////////////////////////////////////////////////////////////
   // apb registers
   logic [`RXM_CTRL_W-1:0] ctrl_reg;
   logic [15:0]            ecnt_reg;
   logic                   err_reg;
   logic                   ais_reg;
   logic                   access;
   logic                   hit;
   logic                   wr_done;
   logic                   report;

   assign access = psel & penable & ~pready;
   // a write lands only at the edge that completes the transfer
   assign wr_done = psel & penable & pready & pwrite;
   assign hit = (paddr == `RXM_CTRL_OFF) || (paddr == `RXM_STAT_OFF)
             || (paddr == `RXM_ECNT_OFF);

   // one wait state keeps prdata and pready straight from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= access;
         pslverr <= access & ~hit;
         prdata  <= 32'h0000_0000;
         if (access && !pwrite) begin
            case (paddr)
               `RXM_CTRL_OFF: prdata <= 32'(ctrl_reg);
               `RXM_STAT_OFF: prdata <= 32'({s2_reg[3], ais_reg});
               `RXM_ECNT_OFF: prdata <= 32'(ecnt_reg);
               default:       prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ctrl_reg <= `RXM_CTRL_RST;
      else if (wr_done && paddr == `RXM_CTRL_OFF)
         ctrl_reg <= pwdata[`RXM_CTRL_W-1:0];
   end

   // error counter: a write clears it, a new error in that cycle still counts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ecnt_reg <= 16'h0000;
      else if (wr_done && paddr == `RXM_ECNT_OFF)
         ecnt_reg <= {15'h0000, bit_stb & report};
      else if (bit_stb && report && ecnt_reg != 16'hFFFF)
         ecnt_reg <= ecnt_reg + 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////
   // configuration: register in host mode, straps otherwise
   rxm_cfg_t cfg;
   always_comb begin
      cfg.host   = s2_reg[3];
      cfg.bypass = cfg.host & ctrl_reg[`RXM_B_BYPASS];
      cfg.ami    = cfg.host ? ctrl_reg[`RXM_B_LCODE] : s2_reg[4];
      cfg.e1     = cfg.host ? ctrl_reg[`RXM_B_E1] : s2_reg[6];
      cfg.crit   = ctrl_reg[`RXM_B_CRIT];
      // bypass falls back to raw dual rail, so no error report then
      cfg.single = (cfg.host ? ctrl_reg[`RXM_B_SRAIL] : s2_reg[5]) & ~cfg.bypass;
      cfg.cvmask = cfg.host & ctrl_reg[`RXM_B_CVMASK];
      cfg.ezrep  = ~cfg.host | ctrl_reg[`RXM_B_EZREP];
   end

   ////////////////////////////////////////////////////////////////////
   // line code checking
   logic          seen_m_reg;
   logic          last_pol_reg;
   logic          seen_v_reg;
   logic          last_vpol_reg;
   logic          in_sub_reg;
   logic [ZW-1:0] zrun_reg;
   logic          mark;
   logic          viol;
   logic          sub_ok;
   rxm_err_t      ev;

   function automatic logic [ZW-1:0] run_limit(input logic e1);
      return e1 ? ZW'(`RXM_HDB3_RUN) : ZW'(`RXM_B8ZS_RUN);
   endfunction

   always_comb begin
      mark   = pos_s | neg_s;
      viol   = mark & seen_m_reg & (pos_s == last_pol_reg);
      sub_ok = cfg.e1 ? (zrun_reg >= ZW'(2))
                      : (zrun_reg == ZW'(3)) || (in_sub_reg && zrun_reg == ZW'(1));
      ev.bpv = viol & (cfg.ami | ~sub_ok);
      ev.cv  = ~cfg.ami & cfg.e1 & viol & sub_ok & seen_v_reg
             & (pos_s == last_vpol_reg);
      ev.ez  = ~cfg.ami & ~mark & (zrun_reg == run_limit(cfg.e1) - ZW'(1));
      report = cfg.single & (ev.bpv
             | (ev.cv & ~cfg.cvmask)
             | (ev.ez & cfg.ezrep));
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen_m_reg    <= 1'b0;
         last_pol_reg  <= 1'b0;
         seen_v_reg    <= 1'b0;
         last_vpol_reg <= 1'b0;
         in_sub_reg    <= 1'b0;
         zrun_reg      <= '0;
      end else if (bit_stb) begin
         if (mark) begin
            seen_m_reg   <= 1'b1;
            last_pol_reg <= pos_s;
            zrun_reg     <= '0;
         end else if (zrun_reg != '1) begin
            zrun_reg <= zrun_reg + ZW'(1);
         end
         if (viol) begin
            seen_v_reg    <= 1'b1;
            last_vpol_reg <= pos_s;
         end
         if (viol && sub_ok && !cfg.e1)
            in_sub_reg <= 1'b1;
         else if (zrun_reg >= ZW'(2))
            in_sub_reg <= 1'b0;
      end
   end

   // outputs change only on a bit strobe, so a pulse spans one bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_reg               <= 1'b0;
         rx_data_out           <= 1'b0;
         receive_negative_rail <= 1'b0;
      end else if (bit_stb) begin
         err_reg               <= report;
         rx_data_out           <= cfg.single ? mark : pos_s;
         receive_negative_rail <= cfg.single ? report : neg_s;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // alarm indication: zero density per block
   logic [BW-1:0] bcnt_reg;
   logic [ZW-1:0] zcnt_reg;
   logic          prev_low_reg;
   logic          ais_en;
   logic          blk_end;
   logic [ZW-1:0] zeros_now;
   logic          low;

   assign ais_en    = cfg.host & ~cfg.bypass;
   assign blk_end   = bit_stb && bcnt_reg == (cfg.e1 ? BW'(E1_BLOCK - 1)
                                                     : BW'(T1_BLOCK - 1));
   assign zeros_now = (zcnt_reg == '1 || mark) ? zcnt_reg : zcnt_reg + ZW'(1);
   assign low       = zeros_now < (cfg.e1 ? ZW'(`RXM_E1_ZEROS)
                                          : ZW'(`RXM_T1_ZEROS));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bcnt_reg     <= '0;
         zcnt_reg     <= '0;
         prev_low_reg <= 1'b0;
      end else if (!ais_en) begin
         bcnt_reg     <= '0;
         zcnt_reg     <= '0;
         prev_low_reg <= 1'b0;
      end else if (blk_end) begin
         bcnt_reg     <= '0;
         zcnt_reg     <= '0;
         prev_low_reg <= low;
      end else if (bit_stb) begin
         bcnt_reg <= bcnt_reg + BW'(1);
         zcnt_reg <= zeros_now;
      end
   end

   // with criterion 0 clearing also waits for a good block
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ais_reg <= 1'b0;
      else if (!ais_en)
         ais_reg <= 1'b0;
      else if (blk_end && !low)
         ais_reg <= 1'b0;
      else if (blk_end && (!cfg.e1 || cfg.crit || prev_low_reg))
         ais_reg <= 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ais_out <= 1'b0;
      else
         ais_out <= ais_reg;
   end

   ////////////////////////////////////////////////////////////////////
   // assertions
   a_ais_gate: assert property (@(posedge pclk) disable iff (!presetn)
      !ais_en |=> !ais_reg) else $error("alarm set while disabled");
   a_e1_two_blocks: assert property (@(posedge pclk) disable iff (!presetn)
      blk_end && ais_en && cfg.e1 && !cfg.crit && low && !prev_low_reg && !ais_reg
      |=> !ais_reg) else $error("alarm after one bad e1 block");
   a_e1_one_block: assert property (@(posedge pclk) disable iff (!presetn)
      blk_end && ais_en && cfg.e1 && cfg.crit && low |=> ais_reg ##1 ais_out)
      else $error("alarm missed on bad e1 block");
   a_e1_clear: assert property (@(posedge pclk) disable iff (!presetn)
      blk_end && ais_en && cfg.e1 && cfg.crit && !low |=> !ais_reg)
      else $error("alarm kept after good e1 block");
   a_t1_set: assert property (@(posedge pclk) disable iff (!presetn)
      blk_end && ais_en && !cfg.e1 && low |=> ais_reg)
      else $error("alarm missed on bad t1 block");
   a_t1_clear: assert property (@(posedge pclk) disable iff (!presetn)
      blk_end && ais_en && !cfg.e1 && !low |=> !ais_reg)
      else $error("alarm kept after good t1 block");
   a_bpv_report: assert property (@(posedge pclk) disable iff (!presetn)
      bit_stb && ev.bpv && cfg.single |=> receive_negative_rail && err_reg)
      else $error("bipolar violation not reported");
   a_ami_only: assert property (@(posedge pclk) disable iff (!presetn)
      bit_stb && cfg.ami && !viol |=> !err_reg)
      else $error("ami reported non bpv error");
   a_dual_rail: assert property (@(posedge pclk) disable iff (!presetn)
      bit_stb && !cfg.single |=> receive_negative_rail == $past(neg_s) && !err_reg)
      else $error("error reported in dual rail");
   a_cv_mask: assert property (@(posedge pclk) disable iff (!presetn)
      bit_stb && cfg.host && cfg.cvmask && !ev.bpv && !(ev.ez && cfg.ezrep)
      |=> !err_reg) else $error("masked code violation reported");
   a_ez_report: assert property (@(posedge pclk) disable iff (!presetn)
      bit_stb && cfg.single && ev.ez && cfg.ezrep |=> err_reg)
      else $error("excess zeros not reported");
   a_err_width: assert property (@(posedge pclk) disable iff (!presetn)
      !bit_stb |=> $stable(err_reg) && $stable(receive_negative_rail))
      else $error("error pin moved between bits");
   a_ais_out_off: assert property (@(posedge pclk) disable iff (!presetn)
      !ais_en |=> ##1 !ais_out)
      else $error("alarm output kept while disabled");
   a_e1_second_bad: assert property (@(posedge pclk) disable iff (!presetn)
      blk_end && ais_en && cfg.e1 && !cfg.crit && low && prev_low_reg |=> ais_reg)
      else $error("alarm missed after two bad e1 blocks");
   a_strap_all: assert property (@(posedge pclk) disable iff (!presetn)
      bit_stb && !cfg.host && cfg.single && (ev.bpv || ev.cv || ev.ez) |=> err_reg)
      else $error("strap mode error not reported");
   a_single_data: assert property (@(posedge pclk) disable iff (!presetn)
      bit_stb && cfg.single |=> rx_data_out == $past(mark))
      else $error("single rail data wrong");
   a_cv_report: assert property (@(posedge pclk) disable iff (!presetn)
      bit_stb && cfg.single && ev.cv && !cfg.cvmask |=> err_reg)
      else $error("code violation not reported");
   a_ez_mask: assert property (@(posedge pclk) disable iff (!presetn)
      bit_stb && !cfg.ezrep && !ev.bpv && !(ev.cv && !cfg.cvmask) |=> !err_reg)
      else $error("unselected excess zeros reported");
   a_ami_code: assert property (@(posedge pclk) disable iff (!presetn)
      cfg.ami |-> !ev.cv && !ev.ez)
      else $error("ami decoded a coded error");
   a_raw_rails: assert property (@(posedge pclk) disable iff (!presetn)
      bit_stb && cfg.bypass |=> rx_data_out == $past(pos_s)
      && receive_negative_rail == $past(neg_s))
      else $error("bypass rails not raw");
   a_err_clear: assert property (@(posedge pclk) disable iff (!presetn)
      bit_stb && !report |=> !err_reg)
      else $error("error pin high without error");
endmodule // rxm_monitor

// File: design/rxm_map.svh
`ifndef RXM_MAP_SVH
`define RXM_MAP_SVH
// apb byte offsets
`define RXM_CTRL_OFF   12'h000
`define RXM_STAT_OFF   12'h004
`define RXM_ECNT_OFF   12'h008
// control register fields
`define RXM_B_LCODE    0
`define RXM_B_E1       1
`define RXM_B_CRIT     2
`define RXM_B_SRAIL    3
`define RXM_B_BYPASS   4
`define RXM_B_CVMASK   5
`define RXM_B_EZREP    6
`define RXM_CTRL_W     7
`define RXM_CTRL_RST   7'h00
// status register fields
`define RXM_B_AIS      0
`define RXM_B_HOST     1
// alarm windows and zero limits
`define RXM_E1_BLOCK   512
`define RXM_T1_BLOCK   8192
`define RXM_E1_ZEROS   3
`define RXM_T1_ZEROS   9
`define RXM_HDB3_RUN   4
`define RXM_B8ZS_RUN   8
`endif

// File: design/rxm_pkg.sv
package rxm_pkg;
   // decoded configuration of one channel
   typedef struct packed {
      logic host;
      logic ami;
      logic e1;
      logic crit;
      logic single;
      logic bypass;
      logic cvmask;
      logic ezrep;
   } rxm_cfg_t;

   // error events of one received bit
   typedef struct packed {
      logic bpv;
      logic cv;
      logic ez;
   } rxm_err_t;
endpackage

// File: verif/rxm_line_tx.sv
`timescale 1ns/1ps
module rxm_line_tx (
   // clock
   input  wire logic pclk,
   // line
   output logic      rx_clk,
   output logic      rx_pos,
   output logic      rx_neg
);
   logic last_neg;

   initial begin
      rx_clk = 1'b0;
      rx_pos = 1'b0;
      rx_neg = 1'b0;
      last_neg = 1'b1;
   end

   // marks alternate; viol repeats the previous polarity
   task automatic send(input logic mark, input logic viol);
      logic pol;
      pol = viol ? last_neg : ~last_neg;
      @(posedge pclk);
      rx_pos <= mark & ~pol;
      rx_neg <= mark & pol;
      if (mark) last_neg = pol;
      repeat (2) @(posedge pclk);
      rx_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      // outside the sample point the rails show junk
      rx_clk <= 1'b0;
      rx_pos <= ~rx_pos;
      rx_neg <= ~rx_neg;
      repeat (2) @(posedge pclk);
   endtask
endmodule // rxm_line_tx

// File: verif/testbench.sv
`timescale 1ns/1ps
`include "rxm_map.svh"
module testbench;
   localparam logic [31:0] LC = 32'h01, E1 = 32'h02, CR = 32'h04, SR = 32'h08;
   localparam logic [31:0] BY = 32'h10, CM = 32'h20, EZ = 32'h40;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, qerr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic        rx_clk, rx_pos, rx_neg, host_mode, line_code_pin, single_rail_pin;
   logic        e1_pin, rx_data_out, neg_rail, ais_out;
   int          err_total = 0;
   int          total_checks = 0;

   rxm_monitor #(.T1_BLOCK(64), .E1_BLOCK(32)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_clk(rx_clk), .rx_pos(rx_pos),
      .rx_neg(rx_neg), .host_mode(host_mode), .line_code_pin(line_code_pin),
      .single_rail_pin(single_rail_pin), .e1_pin(e1_pin),
      .rx_data_out(rx_data_out), .receive_negative_rail(neg_rail), .ais_out(ais_out));

   rxm_line_tx lt (.pclk(pclk), .rx_clk(rx_clk), .rx_pos(rx_pos), .rx_neg(rx_neg));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no cycle count assumed; the watchdog ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      qerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // bypass pulse restarts the alarm block count
   task automatic cfg(input logic [31:0] c);
      apb(1'b1, `RXM_CTRL_OFF, c | BY);
      apb(1'b1, `RXM_CTRL_OFF, c);
   endtask

   task automatic run(input logic [63:0] m, input logic [63:0] v, input int n, output int e);
      e = 0;
      for (int i = 0; i < n; i++) begin
         lt.send(m[i], v[i]);
         e += int'(neg_rail);
      end
   endtask

   task automatic ais(input logic exp);
      chk({31'h0, ais_out}, {31'h0, exp});
      apb(1'b0, `RXM_STAT_OFF, 32'h0);
      chk(q, {30'h0, 1'b1, exp});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      apb(1'b0, `RXM_CTRL_OFF, 32'h0);
      chk(q, 32'h0);
      apb(1'b1, `RXM_CTRL_OFF, 32'hFFFFFFFF);
      apb(1'b0, `RXM_CTRL_OFF, 32'h0);
      chk(q, 32'h7F);
      apb(1'b0, 12'h0FC, 32'h0);
      chk({31'h0, qerr}, 32'h1);
      chk(q, 32'h0);
   endtask

   task automatic t_ais();
      int e;
      apb(1'b1, `RXM_CTRL_OFF, E1 | CR | SR | BY);
      run('1, 0, 32, e);
      ais(1'b0);
      cfg(E1 | CR | SR);
      run('1 << 2, 0, 32, e);
      ais(1'b1);
      run('1 << 3, 0, 32, e);
      ais(1'b0);
      cfg(SR);
      run('1 << 8, 0, 64, e);
      ais(1'b1);
      run('1 << 9, 0, 64, e);
      ais(1'b0);
      cfg(E1 | SR);
      run('1 << 2, 0, 32, e);
      ais(1'b0);
      run('1 << 2, 0, 32, e);
      ais(1'b1);
   endtask

   // dual rail and bypass show the raw rails, single rail the mark
   task automatic rail(input logic s, input logic m, input logic v);
      logic [31:0] x;
      lt.send(m, v);
      x = s ? {30'h0, m, 1'b0} : {30'h0, m & ~lt.last_neg, m & lt.last_neg};
      chk({30'h0, rx_data_out, neg_rail}, x);
   endtask

   task automatic t_dual();
      apb(1'b1, `RXM_CTRL_OFF, E1);
      rail(1'b0, 1'b1, 1'b0);
      rail(1'b0, 1'b1, 1'b1);
      rail(1'b0, 1'b0, 1'b0);
      apb(1'b1, `RXM_CTRL_OFF, E1 | SR | BY);
      rail(1'b0, 1'b1, 1'b1);
      rail(1'b0, 1'b1, 1'b0);
      apb(1'b1, `RXM_CTRL_OFF, E1 | SR);
      rail(1'b1, 1'b1, 1'b0);
      rail(1'b1, 1'b0, 1'b0);
   endtask

   // mark, bpv, three zeros, substitution, four zeros, mark
   task automatic t_err();
      int e;
      apb(1'b1, `RXM_ECNT_OFF, 32'h0);
      for (int k = 0; k < 4; k++) begin
         cfg(E1 | SR | (k[0] ? CM : 32'h0) | (k[1] ? EZ : 32'h0));
         run(64'h423, 64'h022, 11, e);
         chk(e, 2 - k[0] + k[1]);
      end
      cfg(E1 | SR | LC | EZ);
      run(64'h423, 64'h022, 11, e);
      chk(e, 32'd2);
      @(posedge pclk);
      host_mode       <= 1'b0;
      e1_pin          <= 1'b1;
      single_rail_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      run(64'h423, 64'h022, 11, e);
      chk(e, 32'd3);
      apb(1'b0, `RXM_ECNT_OFF, 32'h0);
      chk(q, 32'h0000000D);
   endtask

   task automatic finish_test();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {line_code_pin, single_rail_pin, e1_pin} = '0;
      host_mode = 1'b1;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_dual();
      t_ais();
      t_err();
      finish_test();
   end

   initial begin
      #600us;
      err_total++;
      finish_test();
   end
endmodule // testbench
